/* File: design/ictf_params.svh */
// Register offsets, field positions, reset values and counts of the cycle timer block
`ifndef ICTF_PARAMS_SVH
`define ICTF_PARAMS_SVH
`define ICTF_OFS_VERSION 8'h00
`define ICTF_OFS_CTRL 8'h08
`define ICTF_OFS_STAT 8'h0C
`define ICTF_OFS_CYT 8'h14
`define ICTF_OFS_QSIZE 8'h28
`define ICTF_OFS_QCTL 8'h30
`define ICTF_OFS_TXCRC 8'h34
`define ICTF_OFS_RXSTAT 8'h3C
`define ICTF_OFS_RXQ 8'hC0
`define ICTF_TXQ_PAGE 3'h4
`define ICTF_CTRL_CTE 0
`define ICTF_CTRL_MASTER 1
`define ICTF_CTRL_SRC 2
`define ICTF_STAT_CST 0
`define ICTF_STAT_CLOST 1
`define ICTF_QCTL_CLR 0
`define ICTF_CTRL_RESET 3'h0
`define ICTF_ATF_RESET 10'h080
`define ICTF_ITF_RESET 10'h080
`define ICTF_Q_TOTAL 11'h200
`define ICTF_OFS_LAST 12'hBFF
`define ICTF_CYC_LAST 13'h1F3F
`define ICTF_NORM_WAIT 4'h6
`define ICTF_QUICK_WAIT 4'h0
`define ICTF_CRC_INIT 32'hFFFF_FFFF
`define ICTF_CRC_POLY 32'h04C1_1DB7
`define ICTF_CRC_RESIDUE 32'hC704_DD7B
`endif

/* File: design/ictf_pkg.sv */
// Types shared by the cycle timer block
package ictf_pkg;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_WAIT = 3'b010,
    HS_ACK = 3'b100
  } ictf_hs_state_t;
  typedef struct packed {
    logic [6:0] seconds;
    logic [12:0] count;
    logic [11:0] offset;
  } ictf_cyc_time_t;
endpackage

/* File: design/ictf_if.sv */
// Carriers between the top module and its timer and queue modules
`timescale 1ns/1ns
interface ictf_tmr_if;
  logic enable;
  logic src;
  logic tick;
  logic ext_edge;
  logic load;
  ictf_pkg::ictf_cyc_time_t load_val;
  ictf_pkg::ictf_cyc_time_t value;
  logic cycle_adv;
  modport ctl (output enable, src, tick, ext_edge, load, load_val, input value, cycle_adv);
  modport tmr (input enable, src, tick, ext_edge, load, load_val, output value, cycle_adv);
endinterface

interface ictf_q_if #(parameter int AW = 9);
  logic clr;
  logic [AW:0] atf_size;
  logic [AW:0] itf_size;
  logic [2:0] push;
  logic [2:0] pop;
  logic [2:0] empty;
  logic [2:0] full;
  logic [31:0] wdata [3];
  logic [31:0] head [3];
  logic [AW:0] cnt [3];
  modport ctl (output clr, atf_size, itf_size, push, pop, wdata,
    input empty, full, head, cnt);
  modport q (input clr, atf_size, itf_size, push, pop, wdata,
    output empty, full, head, cnt);
endinterface

/* File: design/ictf_cycle_timer.sv */
// Cycle timer: offset, cycle count and seconds fields
`timescale 1ns/1ns
`include "ictf_params.svh"
module ictf_cycle_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control and value
  ictf_tmr_if.tmr t
);
  logic [11:0] ofs_reg;
  logic [12:0] cyc_reg;
  logic [6:0] sec_reg;
  logic adv;

  // External source only moves the count; internal offset wrap does it otherwise
  assign adv = t.enable & ~t.load &
    ((t.src & t.ext_edge) | (~t.src & t.tick & (ofs_reg == `ICTF_OFS_LAST)));

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ofs_reg <= 12'h000;
      cyc_reg <= 13'h0000;
      sec_reg <= 7'h00;
    end
    else if (t.load)
    begin
      ofs_reg <= t.load_val.offset;
      cyc_reg <= t.load_val.count;
      sec_reg <= t.load_val.seconds;
    end
    else if (t.enable)
    begin
      if (adv)
      begin
        ofs_reg <= 12'h000;
        if (cyc_reg == `ICTF_CYC_LAST)
        begin
          cyc_reg <= 13'h0000;
          sec_reg <= 7'(sec_reg + 7'h01);
        end
        else
        begin
          cyc_reg <= 13'(cyc_reg + 13'h0001);
        end
      end
      else if (t.tick)
      begin
        // Under the external source the offset still free-runs but never carries
        ofs_reg <= (ofs_reg == `ICTF_OFS_LAST) ? 12'h000 : 12'(ofs_reg + 12'h001);
      end
    end
  end

  assign t.value = {sec_reg, cyc_reg, ofs_reg};
  assign t.cycle_adv = adv;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_offset_wrap: assert property (t.enable && !t.load && !t.src && t.tick && ofs_reg == `ICTF_OFS_LAST
    |=> ofs_reg == 12'h000 && cyc_reg != $past(cyc_reg)) else $error("offset wrap lost");
  chk_timer_stop: assert property (!t.enable && !t.load |=> $stable(t.value))
    else $error("timer moved while disabled");
  chk_ext_edge: assert property (t.enable && !t.load && t.src && t.ext_edge
    |=> ofs_reg == 12'h000 && t.value.count != $past(t.value.count))
    else $error("external edge not taken");
endmodule

/* File: design/ictf_queues.sv */
// Shared storage split into async transmit, iso transmit and receive queues
`timescale 1ns/1ns
`include "ictf_params.svh"
module ictf_queues #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Queue access
  ictf_q_if.q qi
);
  logic [31:0] mem [DEPTH];
  logic [AW:0] base [3];
  logic [AW:0] size [3];
  logic [AW:0] rp_reg [3];
  logic [AW:0] wp_reg [3];
  logic [AW:0] cnt_reg [3];

  function automatic logic [AW:0] ictf_wrap_inc(input logic [AW:0] p, input logic [AW:0] s);
    ictf_wrap_inc = (AW+1)'(p + 1'b1) == s ? '0 : (AW+1)'(p + 1'b1);
  endfunction

  // Receive queue takes whatever the two transmit queues leave
  assign size[0] = qi.atf_size;
  assign size[1] = qi.itf_size;
  assign size[2] = (AW+1)'(DEPTH) - qi.atf_size - qi.itf_size;
  assign base[0] = '0;
  assign base[1] = qi.atf_size;
  assign base[2] = (AW+1)'(qi.atf_size + qi.itf_size);

  for (genvar q = 0; q < 3; q++)
  begin : g_q
    logic do_push;
    logic do_pop;
    assign qi.empty[q] = cnt_reg[q] == '0;
    assign qi.full[q] = cnt_reg[q] == size[q];
    assign do_push = qi.push[q] & ~qi.full[q];
    assign do_pop = qi.pop[q] & ~qi.empty[q];
    assign qi.head[q] = mem[AW'(base[q] + rp_reg[q])];
    assign qi.cnt[q] = cnt_reg[q];
    always_ff @(posedge sys_clk)
    begin
      if (!rst_n || qi.clr)
      begin
        rp_reg[q] <= '0;
        wp_reg[q] <= '0;
        cnt_reg[q] <= '0;
      end
      else
      begin
        if (do_push)
        begin
          wp_reg[q] <= ictf_wrap_inc(wp_reg[q], size[q]);
        end
        if (do_pop)
        begin
          rp_reg[q] <= ictf_wrap_inc(rp_reg[q], size[q]);
        end
        if (do_push && !do_pop)
        begin
          cnt_reg[q] <= (AW+1)'(cnt_reg[q] + 1'b1);
        end
        else if (do_pop && !do_push)
        begin
          cnt_reg[q] <= (AW+1)'(cnt_reg[q] - 1'b1);
        end
      end
    end
  end

  // One writer for the shared store; pushes to different queues land in different words
  always_ff @(posedge sys_clk)
  begin
    for (int k = 0; k < 3; k++)
    begin
      if (qi.push[k] && !qi.full[k])
      begin
        mem[AW'(base[k] + wp_reg[k])] <= qi.wdata[k];
      end
    end
  end
endmodule

/* File: design/ictf_top.sv */
// Isochronous cycle timer, cycle monitor, queue partition, CRC and host register port
`timescale 1ns/1ns
`include "ictf_params.svh"
module ictf_top #(
  parameter logic [31:0] VERSION_ID = 32'h0000_0A01  // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Host bus
  input wire logic host_cs_n,
  input wire logic host_start,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [31:0] host_data_in,
  output logic [31:0] host_data_out,
  output logic host_data_oe,
  output logic cycle_ack,
  // Cycle timing
  input wire logic tclk_in,
  input wire logic ext_cycle_in,
  output logic cycle_tick_out,
  output logic [31:0] cycle_time_out,
  // Cycle-start packets
  input wire logic rx_cs_valid,
  input wire logic [31:0] rx_cs_data,
  input wire logic tx_cs_sent,
  output logic tx_cs_req,
  // Status flags
  output logic cyc_start_flag,
  output logic cyc_lost_flag,
  // Transmit drain
  input wire logic atx_pop,
  output logic [31:0] atx_data,
  output logic atx_data_valid,
  output logic atx_empty,
  input wire logic itx_pop,
  output logic [31:0] itx_data,
  output logic itx_data_valid,
  output logic itx_empty,
  input wire logic tx_crc_clr,
  output logic [31:0] tx_crc,
  // Receive fill
  input wire logic rx_wr,
  input wire logic [31:0] rx_wdata,
  input wire logic rx_crc_clr,
  output logic rx_full,
  output logic rx_crc_good
);
  ictf_tmr_if tmr ();
  ictf_q_if qi ();

  ictf_cycle_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .t(tmr.tmr)
  );

  ictf_queues u_queues (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .qi(qi.q)
  );

  function automatic logic ictf_is_txq(input logic [7:0] a);
    ictf_is_txq = a[7:5] == `ICTF_TXQ_PAGE;
  endfunction

  // Burst is a run of quick handshakes, so burst offsets are a subset here
  function automatic logic ictf_fast_ok(input logic [7:0] a, input logic w);
    if (w)
      ictf_fast_ok = (a == `ICTF_OFS_QCTL) || ictf_is_txq(a);
    else
      ictf_fast_ok = (a == `ICTF_OFS_QCTL) || (a == `ICTF_OFS_TXCRC) ||
        (a == `ICTF_OFS_RXSTAT) || (a == `ICTF_OFS_RXQ);
  endfunction

  function automatic logic [31:0] ictf_crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
    begin
      r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ `ICTF_CRC_POLY) : {r[30:0], 1'b0};
    end
    ictf_crc_step = r;
  endfunction

  // Host pins cross from an unrelated clock; the host holds them stable under start
  logic [42:0] hsync1_reg;
  logic [42:0] hsync2_reg;
  logic [1:0] tsync1_reg;
  logic [1:0] tsync2_reg;
  logic [1:0] tprev_reg;
  logic s_cs_n;
  logic s_start;
  logic s_wr;
  logic [7:0] s_addr;
  logic [31:0] s_data;
  logic start_ok;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      hsync1_reg <= '0;
      hsync2_reg <= '0;
      tsync1_reg <= 2'h0;
      tsync2_reg <= 2'h0;
      tprev_reg <= 2'h0;
    end
    else
    begin
      hsync1_reg <= {host_cs_n, host_start, host_wr, host_addr, host_data_in};
      hsync2_reg <= hsync1_reg;
      tsync1_reg <= {ext_cycle_in, tclk_in};
      tsync2_reg <= tsync1_reg;
      tprev_reg <= tsync2_reg;
    end
  end

  assign {s_cs_n, s_start, s_wr, s_addr, s_data} = hsync2_reg;
  assign start_ok = s_start & ~s_cs_n;

  // Host handshake: four-phase, acknowledge held until start falls
  ictf_pkg::ictf_hs_state_t state_reg;
  logic [3:0] wait_reg;
  logic [7:0] acc_addr_reg;
  logic acc_wr_reg;
  logic [31:0] acc_data_reg;
  logic do_access;
  logic start_fast;

  assign start_fast = ictf_fast_ok(s_addr, s_wr);
  assign do_access = (state_reg == ictf_pkg::HS_WAIT) && (wait_reg == 4'h0);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ictf_pkg::HS_IDLE;
      wait_reg <= 4'h0;
      acc_addr_reg <= 8'h00;
      acc_wr_reg <= 1'b0;
      acc_data_reg <= 32'h0000_0000;
    end
    else
    begin
      case (state_reg)
        ictf_pkg::HS_IDLE:
        begin
          if (start_ok)
          begin
            acc_addr_reg <= s_addr;
            acc_wr_reg <= s_wr;
            acc_data_reg <= s_data;
            wait_reg <= start_fast ? `ICTF_QUICK_WAIT : `ICTF_NORM_WAIT;
            state_reg <= ictf_pkg::HS_WAIT;
          end
        end
        ictf_pkg::HS_WAIT:
        begin
          if (wait_reg == 4'h0)
            state_reg <= ictf_pkg::HS_ACK;
          else
            wait_reg <= 4'(wait_reg - 4'h1);
        end
        ictf_pkg::HS_ACK:
        begin
          if (!s_start)
            state_reg <= ictf_pkg::HS_IDLE;
        end
        default:
        begin
          state_reg <= ictf_pkg::HS_IDLE;
        end
      endcase
    end
  end

  assign cycle_ack = state_reg == ictf_pkg::HS_ACK;
  assign host_data_oe = cycle_ack & ~acc_wr_reg;

  // Register writes
  logic [2:0] ctrl_reg;
  logic [1:0] stat_reg;
  logic [9:0] atf_size_reg;
  logic [9:0] itf_size_reg;
  logic wr_cyt;
  logic wr_stat;
  logic master;
  logic cs_set;
  logic lost_set;
  logic expect_reg;

  assign wr_cyt = do_access & acc_wr_reg & (acc_addr_reg == `ICTF_OFS_CYT);
  assign wr_stat = do_access & acc_wr_reg & (acc_addr_reg == `ICTF_OFS_STAT);
  assign master = ctrl_reg[`ICTF_CTRL_MASTER];

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= `ICTF_CTRL_RESET;
      atf_size_reg <= `ICTF_ATF_RESET;
      itf_size_reg <= `ICTF_ITF_RESET;
    end
    else if (do_access && acc_wr_reg)
    begin
      if (acc_addr_reg == `ICTF_OFS_CTRL)
        ctrl_reg <= acc_data_reg[2:0];
      // A split that overcommits storage is dropped rather than clipped
      if (acc_addr_reg == `ICTF_OFS_QSIZE &&
          11'({1'b0, acc_data_reg[9:0]} + {1'b0, acc_data_reg[25:16]}) <= `ICTF_Q_TOTAL)
      begin
        atf_size_reg <= acc_data_reg[9:0];
        itf_size_reg <= acc_data_reg[25:16];
      end
    end
  end

  // Cycle monitor; a set in the same cycle as a clear wins
  assign cs_set = (master & tx_cs_sent) | (~master & rx_cs_valid);
  assign lost_set = tmr.cycle_adv & ~master & expect_reg & ~rx_cs_valid;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stat_reg <= 2'h0;
      expect_reg <= 1'b0;
      cycle_tick_out <= 1'b0;
      tx_cs_req <= 1'b0;
    end
    else
    begin
      stat_reg <= (stat_reg & ~(wr_stat ? acc_data_reg[1:0] : 2'h0)) | {lost_set, cs_set};
      if (tmr.cycle_adv && !master)
        expect_reg <= 1'b1;
      else if (rx_cs_valid || master)
        expect_reg <= 1'b0;
      cycle_tick_out <= tmr.cycle_adv;
      tx_cs_req <= tmr.cycle_adv & master;
    end
  end

  assign cyc_start_flag = stat_reg[`ICTF_STAT_CST];
  assign cyc_lost_flag = stat_reg[`ICTF_STAT_CLOST];

  // Timer control
  assign tmr.enable = ctrl_reg[`ICTF_CTRL_CTE];
  assign tmr.src = ctrl_reg[`ICTF_CTRL_SRC];
  assign tmr.tick = tsync2_reg[0] & ~tprev_reg[0];
  assign tmr.ext_edge = tsync2_reg[1] & ~tprev_reg[1];
  assign tmr.load = wr_cyt | (rx_cs_valid & ~master);
  assign tmr.load_val = wr_cyt ? acc_data_reg : rx_cs_data;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      cycle_time_out <= 32'h0000_0000;
    else
      cycle_time_out <= tmr.value;
  end

  // Queues: host writes transmit pages, reads only the receive port
  logic atx_ok;
  logic itx_ok;
  logic host_txq_wr;

  assign host_txq_wr = do_access & acc_wr_reg & ictf_is_txq(acc_addr_reg);
  assign qi.clr = do_access & acc_wr_reg & (acc_addr_reg == `ICTF_OFS_QCTL) &
    acc_data_reg[`ICTF_QCTL_CLR];
  assign qi.atf_size = atf_size_reg;
  assign qi.itf_size = itf_size_reg;
  assign qi.push = {rx_wr, host_txq_wr & acc_addr_reg[4], host_txq_wr & ~acc_addr_reg[4]};
  assign qi.pop = {do_access & ~acc_wr_reg & (acc_addr_reg == `ICTF_OFS_RXQ), itx_pop, atx_pop};
  assign qi.wdata[0] = acc_data_reg;
  assign qi.wdata[1] = acc_data_reg;
  assign qi.wdata[2] = rx_wdata;
  assign atx_empty = qi.empty[0];
  assign itx_empty = qi.empty[1];
  assign rx_full = qi.full[2];
  assign atx_ok = atx_pop & ~qi.empty[0];
  assign itx_ok = itx_pop & ~qi.empty[1];

  // Transmit and receive CRC; one transmitter word per cycle is assumed
  logic [31:0] tx_crc_reg;
  logic [31:0] rx_crc_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      atx_data <= 32'h0000_0000;
      itx_data <= 32'h0000_0000;
      atx_data_valid <= 1'b0;
      itx_data_valid <= 1'b0;
      tx_crc_reg <= `ICTF_CRC_INIT;
      rx_crc_reg <= `ICTF_CRC_INIT;
    end
    else
    begin
      atx_data_valid <= atx_ok;
      itx_data_valid <= itx_ok;
      if (atx_ok)
        atx_data <= qi.head[0];
      if (itx_ok)
        itx_data <= qi.head[1];
      if (tx_crc_clr)
        tx_crc_reg <= `ICTF_CRC_INIT;
      else if (atx_ok || itx_ok)
        tx_crc_reg <= ictf_crc_step(tx_crc_reg, atx_ok ? qi.head[0] : qi.head[1]);
      if (rx_crc_clr)
        rx_crc_reg <= `ICTF_CRC_INIT;
      else if (rx_wr)
        rx_crc_reg <= ictf_crc_step(rx_crc_reg, rx_wdata);
    end
  end

  assign tx_crc = ~tx_crc_reg;
  assign rx_crc_good = rx_crc_reg == `ICTF_CRC_RESIDUE;

  // Register reads; transmit pages and unmapped offsets read zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      host_data_out <= 32'h0000_0000;
    else if (do_access && !acc_wr_reg)
    begin
      case (acc_addr_reg)
        `ICTF_OFS_VERSION: host_data_out <= VERSION_ID;
        `ICTF_OFS_CTRL: host_data_out <= {29'h0000_0000, ctrl_reg};
        `ICTF_OFS_STAT: host_data_out <= {30'h0000_0000, stat_reg};
        `ICTF_OFS_CYT: host_data_out <= tmr.value;
        `ICTF_OFS_QSIZE: host_data_out <= {6'h00, itf_size_reg, 6'h00, atf_size_reg};
        `ICTF_OFS_QCTL: host_data_out <= {2'h0, qi.cnt[2], qi.cnt[1], qi.cnt[0]};
        `ICTF_OFS_TXCRC: host_data_out <= tx_crc;
        `ICTF_OFS_RXSTAT: host_data_out <= {31'h0000_0000, rx_crc_good};
        `ICTF_OFS_RXQ: host_data_out <= qi.empty[2] ? 32'h0000_0000 : qi.head[2];
        default: host_data_out <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_take_normal;
    state_reg == ictf_pkg::HS_IDLE && start_ok && !start_fast;
  endsequence
  sequence s_take_quick;
    state_reg == ictf_pkg::HS_IDLE && start_ok && start_fast;
  endsequence

  chk_ack_normal: assert property (s_take_normal |-> ##1 !cycle_ack [*7] ##1 cycle_ack)
    else $error("normal ack timing wrong");
  chk_ack_quick: assert property (s_take_quick |-> ##1 !cycle_ack ##1 cycle_ack)
    else $error("quick ack timing wrong");
  chk_ack_hold: assert property (cycle_ack && s_start |=> cycle_ack)
    else $error("ack dropped under start");
  chk_tick_out: assert property (tmr.cycle_adv |=> cycle_tick_out)
    else $error("cycle tick missing");
  chk_master_req: assert property (tmr.cycle_adv && master |=> tx_cs_req)
    else $error("cycle start not requested");
  chk_lost_flag: assert property (lost_set |=> cyc_lost_flag)
    else $error("cycle lost not flagged");
  chk_start_flag: assert property (!master && rx_cs_valid |=> cyc_start_flag)
    else $error("cycle start not flagged");
  chk_slave_load: assert property (!master && rx_cs_valid && !wr_cyt
    |=> tmr.value == $past(rx_cs_data)) else $error("timer not loaded");
  chk_size_sum: assert property (11'({1'b0, atf_size_reg} + {1'b0, itf_size_reg})
    <= `ICTF_Q_TOTAL) else $error("queue split overcommits");
  chk_txq_read: assert property (do_access && !acc_wr_reg && ictf_is_txq(acc_addr_reg)
    |=> host_data_out == 32'h0000_0000) else $error("transmit queue readable");
endmodule

/* File: dv/ictf_host_model.sv */
// Host processor model for the start and acknowledge register port
`timescale 1ns/1ns
module ictf_host_model (
  // Clock
  input wire logic sys_clk,
  // Host bus
  output logic host_cs_n,
  output logic host_start,
  output logic host_wr,
  output logic [7:0] host_addr,
  output logic [31:0] host_data_in,
  input wire logic [31:0] host_data_out,
  input wire logic cycle_ack
);
  int lat;
  initial
  begin
    host_cs_n = 1'b1;
    host_start = 1'b0;
    host_wr = 1'b0;
    host_addr = 8'h00;
    host_data_in = 32'h0000_0000;
  end
  // Hold lengthens the time start stays up after the acknowledge
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input int hold, output logic [31:0] q);
    @(negedge sys_clk);
    host_cs_n = 1'b0;
    host_wr = wr;
    host_addr = a;
    host_data_in = d;
    host_start = 1'b1;
    lat = 0;
    // Looked at half a cycle after the edge, where acknowledge and data have settled
    do
    begin
      @(negedge sys_clk);
      lat++;
    end while (cycle_ack !== 1'b1 && lat < 100);
    q = host_data_out;
    repeat (hold) @(negedge sys_clk);
    @(negedge sys_clk);
    host_start = 1'b0;
    host_cs_n = 1'b1;
    // Released data lines never keep the last value; address and write keep theirs
    host_data_in = ~d;
    for (int i = 0; i < 100 && cycle_ack === 1'b1; i++) @(negedge sys_clk);
  endtask
endmodule

/* File: dv/iso_cycle_timer_fifo_host_access_tb.sv */
// Self-checking bench for the cycle timer, queues and host register port
`timescale 1ns/1ns
module iso_cycle_timer_fifo_host_access_tb;
  localparam logic [31:0] VER = 32'h0000_5A17; // Arbitrary value
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tclk_in = 1'b0;
  logic ext_cycle_in = 1'b0;
  logic rx_cs_valid = 1'b0;
  logic [31:0] rx_cs_data = 32'h0000_0000;
  logic tx_cs_sent = 1'b0;
  logic atx_pop = 1'b0;
  logic itx_pop = 1'b0;
  logic tx_crc_clr = 1'b0;
  logic rx_wr = 1'b0;
  logic [31:0] rx_wdata = 32'h0000_0000;
  logic rx_crc_clr = 1'b0;
  logic host_cs_n, host_start, host_wr, cycle_ack, cycle_tick_out, tx_cs_req, req_seen;
  logic cyc_start_flag, cyc_lost_flag, atx_empty, rx_full;
  logic atx_data_valid, itx_data_valid, itx_empty, rx_crc_good, host_data_oe, oe_seen;
  logic [7:0] host_addr;
  logic [31:0] host_data_in, host_data_out, cycle_time_out, atx_data, q, t;
  logic [31:0] itx_data, tx_crc;
  logic [31:0] lfsr = 32'h2aa0_c042;
  logic [31:0] rxq [$];
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  initial forever #4 sys_clk = ~sys_clk;
  // Timing clock has a 125 ns period, unrelated in phase to sys_clk
  initial
  begin
    #3;
    forever
    begin
      #62 tclk_in = ~tclk_in;
      #63 tclk_in = ~tclk_in;
    end
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    req_seen <= (tx_cs_req === 1'b1) ? 1'b1 : (rst_n ? req_seen : 1'b0);
    if (cycles == 60000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  always @(negedge sys_clk)
    if (cycle_ack === 1'b1)
      oe_seen = host_data_oe;
  ictf_top #(.VERSION_ID(VER)) i_ictf_top (.sys_clk(sys_clk), .rst_n(rst_n),
    .host_cs_n(host_cs_n), .host_start(host_start), .host_wr(host_wr),
    .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .cycle_ack(cycle_ack), .tclk_in(tclk_in),
    .ext_cycle_in(ext_cycle_in), .cycle_tick_out(cycle_tick_out),
    .cycle_time_out(cycle_time_out), .rx_cs_valid(rx_cs_valid), .rx_cs_data(rx_cs_data),
    .tx_cs_sent(tx_cs_sent), .tx_cs_req(tx_cs_req), .cyc_start_flag(cyc_start_flag),
    .cyc_lost_flag(cyc_lost_flag), .atx_pop(atx_pop), .atx_data(atx_data),
    .atx_data_valid(atx_data_valid), .atx_empty(atx_empty), .itx_pop(itx_pop),
    .itx_data(itx_data), .itx_data_valid(itx_data_valid), .itx_empty(itx_empty),
    .tx_crc_clr(tx_crc_clr), .tx_crc(tx_crc), .rx_wr(rx_wr), .rx_wdata(rx_wdata),
    .rx_crc_clr(rx_crc_clr), .rx_full(rx_full), .rx_crc_good(rx_crc_good));
  ictf_host_model i_ictf_host_model (.sys_clk(sys_clk), .host_cs_n(host_cs_n),
    .host_start(host_start), .host_wr(host_wr), .host_addr(host_addr),
    .host_data_in(host_data_in), .host_data_out(host_data_out), .cycle_ack(cycle_ack));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Standard 32-bit CRC, most significant data bit first
  function automatic logic [31:0] crc_of(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--)
      c = (c[31] ^ d[i]) ? ({c[30:0], 1'b0} ^ 32'h04C1_1DB7) : {c[30:0], 1'b0};
    return c;
  endfunction
  // Cycle count wraps after 7999 and carries into seconds
  function automatic logic [31:0] cyc_after(input logic [31:0] v);
    if (v[24:12] == 13'h1F3F)
      return {v[31:25] + 7'h01, 25'h000_0000};
    return {v[31:12] + 20'h0_0001, 12'h000};
  endfunction
  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_ictf_host_model.access(1'b1, a, d, 0, q);
  endtask
  task automatic rd(input logic [7:0] a);
    i_ictf_host_model.access(1'b0, a, 32'h0000_0000, 2, q);
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  task automatic wait_tick(input logic [31:0] exp);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (cycle_tick_out !== 1'b1 && n < 3000);
    @(posedge sys_clk);
    #1;
    check32({cycle_time_out[31:12], 12'h000}, exp, "cycle fields");
    check32({31'h0, cycle_time_out[11:0] < 12'h002}, 32'h1, "offset wrap");
  endtask
  task automatic print_verdict();
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(8'h00);
    check32(q, VER, "version");
    check32({31'h0, oe_seen}, 32'h1, "read drive");
    rd(8'h28);
    check32(q, 32'h0080_0080, "sizes");
    rd(8'h80);
    check32(q, 32'h0000_0000, "tx queue read");
    $display("reset test done");
    lfsr = next_rand(lfsr);
    t = {lfsr[31:25], 13'h1F3F, 12'hBF0};
    wr(8'h14, t);
    check32({31'h0, oe_seen}, 32'h0, "write no drive");
    rd(8'h14);
    check32(q, t, "timer readback");
    wr(8'h08, 32'h0000_0001);
    wait_tick(cyc_after(t));
    wr(8'h08, 32'h0000_0000);
    t = cycle_time_out;
    repeat (100) @(posedge sys_clk);
    check32(cycle_time_out, t, "stopped timer");
    n = i_ictf_host_model.lat;
    rd(8'h30);
    check32({31'h0, i_ictf_host_model.lat < n}, 32'h1, "quick ack");
    $display("internal timer test done");
    lfsr = next_rand(lfsr);
    t = {lfsr[31:25], 1'b0, lfsr[23:12], 12'h100};
    wr(8'h14, t);
    wr(8'h08, 32'h0000_0007);
    pulse(ext_cycle_in);
    wait_tick(cyc_after(t));
    check32({31'h0, req_seen}, 32'h1, "start request");
    pulse(tx_cs_sent);
    repeat (3) @(posedge sys_clk);
    check32({31'h0, cyc_start_flag}, 32'h1, "start flag");
    wr(8'h0C, 32'h0000_0003);
    $display("external source test done");
    wr(8'h08, 32'h0000_0001);
    lfsr = next_rand(lfsr);
    rx_cs_data = {lfsr[31:25], 1'b0, lfsr[23:12], 12'hBF8};
    pulse(rx_cs_valid);
    repeat (3) @(posedge sys_clk);
    check32({cycle_time_out[31:12], 12'h000}, {rx_cs_data[31:12], 12'h000}, "load");
    check32({31'h0, cyc_start_flag}, 32'h1, "start flag rx");
    wait_tick(cyc_after(rx_cs_data));
    wr(8'h14, rx_cs_data);
    wait_tick(cyc_after(rx_cs_data));
    repeat (3) @(posedge sys_clk);
    check32({31'h0, cyc_lost_flag}, 32'h1, "lost flag");
    $display("monitor test done");
    wr(8'h30, 32'h0000_0001);
    wr(8'h28, 32'h0064_00C8);
    wr(8'h28, 32'h0180_0100);
    rd(8'h28);
    check32(q, 32'h0064_00C8, "resize");
    n = 0;
    while (rx_full !== 1'b1 && n < 600)
    begin
      lfsr = next_rand(lfsr);
      rxq.push_back(lfsr);
      rx_wdata = lfsr;
      pulse(rx_wr);
      n++;
    end
    check32(n, 32'd212, "rx depth");
    repeat (3)
    begin
      rd(8'hC0);
      check32(q, rxq.pop_front(), "rx read");
    end
    pulse(rx_crc_clr);
    rx_wdata = lfsr;
    pulse(rx_wr);
    rx_wdata = ~crc_of(32'hFFFF_FFFF, lfsr);
    pulse(rx_wr);
    check32({31'h0, rx_crc_good}, 32'h1, "rx crc");
    lfsr = next_rand(lfsr);
    wr(8'h80, lfsr);
    wr(8'h84, ~lfsr);
    wr(8'h90, t);
    rd(8'h30);
    check32({12'h0, q[19:0]}, 32'h0000_0402, "tx count");
    pulse(tx_crc_clr);
    pulse(atx_pop);
    check32(atx_data, lfsr, "tx drain");
    check32({30'h0, atx_data_valid, atx_empty}, 32'h2, "tx valid");
    pulse(atx_pop);
    pulse(itx_pop);
    check32(itx_data, t, "iso drain");
    check32({29'h0, itx_data_valid, itx_empty, atx_empty}, 32'h7, "drain flags");
    check32(tx_crc, ~crc_of(crc_of(crc_of(32'hFFFF_FFFF, lfsr), ~lfsr), t), "tx crc");
    $display("queue test done");
    print_verdict();
  end
endmodule
